//--- core/dmt_controller.sv
// Controller end: interval counters gating commands, APB register slave
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dmt_controller
	import dmt_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	dmt_link_if.ctrl link,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT
);
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_CFG = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam int CFG_REFMODE_LSB = 0;
	localparam int CFG_CRCDM_BIT = 2;
	localparam int CFG_PERSIST_BIT = 3;
	localparam int CFG_DLL_UNLOCK_BIT = 4;
	localparam int CFG_CKE_BIT = 5;
	localparam int CMD_INJ_PAR_BIT = 4;
	localparam int CMD_INJ_CRC_BIT = 5;
	localparam int CMD_LEVEL_BIT = 6;
	localparam int NCNT = 6;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ISSUE = 3'b010,
		ST_DONE = 3'b100
	} dmt_state_t;
	dmt_state_t st_reg, st_next;
	logic [31:0] cfg_reg, cfg_next;
	logic [6:0] cmd_reg, cmd_next;
	logic [CNT_W-1:0] cnt_reg [NCNT];
	logic [CNT_W-1:0] cnt_next [NCNT];
	logic alert_s1_reg, alert_s2_reg, alert_seen_reg, alert_seen_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic cv_reg, cv_next, pe_reg, pe_next, ce_reg, ce_next;
	logic se_reg, se_next, sg_reg, sg_next;
	logic [3:0] lc_reg, lc_next;
	logic blocked, apb_wr, apb_rd, mapped;
	logic [CNT_W-1:0] wr_rec;
	// Counter slots: 0 mode, 1 refresh, 2 level strobe, 3 level edge,
	// 4 loop lock, 5 write recovery; one each so no constraint hides another
	always_comb begin
		wr_rec = cfg_reg[CFG_CRCDM_BIT] ?
			CNT_W'(ns_to_cyc(WRITE_RECOVERY_CRC_DM_NS)) :
			CNT_W'(ns_to_cyc(WRITE_RECOVERY_NS));
		case (cmd_reg[3:0])
			CMD_MRS: blocked = cnt_reg[0] != '0;
			CMD_ACT, CMD_REF: blocked = cnt_reg[1] != '0;
			CMD_RD, CMD_RDA, CMD_ODT: blocked = cnt_reg[4] != '0 ||
				cnt_reg[0] != '0;
			default: blocked = cnt_reg[0] != '0;
		endcase
		if (alert_seen_reg && cfg_reg[CFG_PERSIST_BIT])
			blocked = 1'b1;
		mapped = PADDR_IN == REG_CMD || PADDR_IN == REG_CFG ||
			PADDR_IN == REG_STATUS;
		// Write lands on the edge where the master samples ready high
		apb_wr = PSEL_IN && PENABLE_IN && pready_reg && PWRITE_IN;
		apb_rd = PSEL_IN && PENABLE_IN && !pready_reg && !PWRITE_IN;
	end
	always_comb begin
		st_next = st_reg;
		cfg_next = cfg_reg;
		cmd_next = cmd_reg;
		cv_next = 1'b0;
		pe_next = 1'b0;
		ce_next = 1'b0;
		lc_next = CMD_DES;
		se_next = se_reg;
		sg_next = 1'b0;
		alert_seen_next = alert_seen_reg || !alert_s2_reg;
		for (int i = 0; i < NCNT; i++)
			cnt_next[i] = (cnt_reg[i] != '0) ? cnt_reg[i] - 1'b1 : cnt_reg[i];
		// Strobe drivers and first edge only after leveling waits
		if (cnt_reg[2] == CNT_W'(1))
			se_next = 1'b1;
		if (cnt_reg[3] == CNT_W'(1))
			sg_next = 1'b1;
		pready_next = PSEL_IN && PENABLE_IN && !pready_reg;
		pslverr_next = pready_next && !mapped;
		prdata_next = '0;
		case (st_reg)
			ST_IDLE: begin
				if (apb_wr && PADDR_IN == REG_CMD) begin
					cmd_next = PWDATA_IN[6:0];
					st_next = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (!blocked) begin
					cv_next = 1'b1;
					lc_next = cmd_reg[3:0];
					pe_next = cmd_reg[CMD_INJ_PAR_BIT];
					ce_next = cmd_reg[CMD_INJ_CRC_BIT];
					case (cmd_reg[3:0])
						CMD_MRS: begin
							cnt_next[0] = CNT_W'(imax(MODE_GAP_DEV,
								UPDATE_DELAY_CYC));
							if (cmd_reg[CMD_LEVEL_BIT]) begin
								se_next = 1'b0;
								cnt_next[2] = CNT_W'(LEVEL_STROBE_EN_CYC);
								cnt_next[3] = CNT_W'(LEVEL_FIRST_STROBE_CYC);
							end
						end
						CMD_REF: cnt_next[1] =
							ref_cycles(cfg_reg[CFG_REFMODE_LSB +: 2]);
						CMD_WR: cnt_next[5] = CNT_W'(WRITE_LATENCY_CYC +
							WRITE_START_BL8_CYC) + wr_rec;
						CMD_WRA: cnt_next[5] = CNT_W'(WRITE_LATENCY_CYC +
							WRITE_START_BL8_CYC + MODE_ZERO_WR_CYC + 1);
						default: ;
					endcase
					st_next = ST_DONE;
				end
			end
			ST_DONE: st_next = ST_IDLE;
			default: st_next = ST_IDLE;
		endcase
		if (cfg_reg[CFG_DLL_UNLOCK_BIT] && !needs_lock(CMD_DES)) begin
			cfg_next[CFG_DLL_UNLOCK_BIT] = 1'b0;
			cnt_next[4] = CNT_W'(PDE_PENDING_CYC * 100);
		end
		if (apb_wr && PADDR_IN == REG_CFG)
			cfg_next = PWDATA_IN;
		if (apb_wr && PADDR_IN == REG_STATUS)
			alert_seen_next = !alert_s2_reg; // Set wins over clear
		if (apb_rd && PADDR_IN == REG_CFG)
			prdata_next = cfg_reg;
		if (apb_rd && PADDR_IN == REG_STATUS)
			prdata_next = {24'h0, st_reg == ST_IDLE, cnt_reg[5] != '0,
				cnt_reg[1] != '0, cnt_reg[0] != '0, se_reg,
				alert_seen_reg, !alert_s2_reg, blocked};
		if (apb_rd && PADDR_IN == REG_CMD)
			prdata_next = {25'h0, cmd_reg};
	end
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			st_reg <= ST_IDLE;
			cfg_reg <= '0;
			cmd_reg <= '0;
			for (int i = 0; i < NCNT; i++)
				cnt_reg[i] <= '0;
			alert_s1_reg <= 1'b1;
			alert_s2_reg <= 1'b1;
			alert_seen_reg <= 1'b0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			cv_reg <= 1'b0;
			pe_reg <= 1'b0;
			ce_reg <= 1'b0;
			lc_reg <= CMD_DES;
			se_reg <= 1'b0;
			sg_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cfg_reg <= cfg_next;
			cmd_reg <= cmd_next;
			for (int i = 0; i < NCNT; i++)
				cnt_reg[i] <= cnt_next[i];
			alert_s1_reg <= link.alert_n;
			alert_s2_reg <= alert_s1_reg;
			alert_seen_reg <= alert_seen_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			cv_reg <= cv_next;
			pe_reg <= pe_next;
			ce_reg <= ce_next;
			lc_reg <= lc_next;
			se_reg <= se_next;
			sg_reg <= sg_next;
		end
	end
	// Deselect is sent whenever no command issues
	assign link.cmd_valid = cv_reg;
	assign link.cmd = lc_reg;
	assign link.cmd_parity_err = pe_reg;
	assign link.crc_err = ce_reg;
	assign link.strobe_en = se_reg;
	assign link.strobe_edge = sg_reg;
	assign link.cke = cfg_reg[CFG_CKE_BIT];
	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = pready_reg;
	assign PSLVERR_OUT = pslverr_reg;
endmodule : dmt_controller

//--- core/dmt_pkg.sv
// Package: timing constants and command codes shared by both ends
package dmt_pkg;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int MODE_GAP_DEV_CYC = 16;
	localparam int MODE_GAP_DEV_NS = 10;
	localparam int UPDATE_DELAY_CYC = 24;
	localparam int LEVEL_FIRST_STROBE_CYC = 40;
	localparam int LEVEL_STROBE_EN_CYC = 25;
	localparam int PARITY_LATENCY_CYC = 6;
	localparam int PAR_ALERT_EXTRA_NS = 6;
	localparam int PAR_ALERT_MIN_CYC = 88;
	localparam int PAR_ALERT_MAX_CYC = 176;
	localparam int PAR_ALERT_REPLY_CYC = 78;
	localparam int CRC_ALERT_MIN_NS = 3;
	localparam int CRC_ALERT_MAX_NS = 13;
	localparam int CRC_ALERT_WIDTH_MIN_CYC = 6;
	localparam int CRC_ALERT_WIDTH_MAX_CYC = 10;
	localparam int REFRESH_NORMAL_NS = 350;
	localparam int REFRESH_DOUBLE_NS = 260;
	localparam int REFRESH_QUAD_NS = 160;
	localparam int WRITE_LATENCY_CYC = 9;
	localparam int WRITE_START_BL8_CYC = 4;
	localparam int WRITE_START_BC4_CYC = 2;
	localparam int WRITE_RECOVERY_NS = 15;
	localparam int WRITE_RECOVERY_CRC_DM_NS = 20;
	localparam int WTR_S_CYC = 3;
	localparam int WTR_S_CRC_DM_CYC = 5;
	localparam int WTR_L_CYC = 9;
	localparam int WTR_L_CRC_DM_CYC = 11;
	localparam int MODE_ZERO_WR_CYC = 12;
	localparam int PDE_PENDING_CYC = 2;
	// ceiling of ns over the clock period
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : imax
	localparam int MODE_GAP_DEV =
		imax(MODE_GAP_DEV_CYC, ns_to_cyc(MODE_GAP_DEV_NS));
	localparam int PAR_ALERT_ON_CYC =
		PARITY_LATENCY_CYC + (PAR_ALERT_EXTRA_NS * 1000) / CLK_PERIOD_PS;
	localparam int CRC_ALERT_DLY_CYC = ns_to_cyc(CRC_ALERT_MIN_NS);
	localparam int CRC_ALERT_HOLD_CYC = 8;
	localparam int PAR_ALERT_HOLD_CYC = 120;
	localparam int REF_NORMAL_CYC = ns_to_cyc(REFRESH_NORMAL_NS);
	localparam int REF_DOUBLE_CYC = ns_to_cyc(REFRESH_DOUBLE_NS);
	localparam int REF_QUAD_CYC = ns_to_cyc(REFRESH_QUAD_NS);
	localparam int CNT_W = 8;
	localparam logic [3:0] CMD_DES = 4'h0;
	localparam logic [3:0] CMD_MRS = 4'h1;
	localparam logic [3:0] CMD_REF = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_PRE = 4'h4;
	localparam logic [3:0] CMD_WR = 4'h5;
	localparam logic [3:0] CMD_RD = 4'h6;
	localparam logic [3:0] CMD_RDA = 4'h7;
	localparam logic [3:0] CMD_ODT = 4'h8;
	localparam logic [3:0] CMD_WRA = 4'h9;
	localparam logic [1:0] REF_MODE_NORMAL = 2'h0;
	localparam logic [1:0] REF_MODE_DOUBLE = 2'h1;
	localparam logic [1:0] REF_MODE_QUAD = 2'h2;
	// commands that need the loop locked
	function automatic logic needs_lock(input logic [3:0] c);
		return (c == CMD_RD) || (c == CMD_RDA) || (c == CMD_ODT);
	endfunction : needs_lock
	function automatic logic [CNT_W-1:0] ref_cycles(input logic [1:0] m);
		case (m)
			REF_MODE_DOUBLE: ref_cycles = CNT_W'(REF_DOUBLE_CYC);
			REF_MODE_QUAD: ref_cycles = CNT_W'(REF_QUAD_CYC);
			default: ref_cycles = CNT_W'(REF_NORMAL_CYC);
		endcase
	endfunction : ref_cycles
endpackage : dmt_pkg

//--- core/dmt_link_if.sv
// Interface: command bus and alert line between controller and device
`timescale 1ns/1ps
interface dmt_link_if;
	logic cmd_valid;
	logic [3:0] cmd;
	logic cmd_parity_err;
	logic crc_err;
	logic strobe_en;
	logic strobe_edge;
	logic cke;
	logic alert_n;
	modport ctrl (output cmd_valid, output cmd, output cmd_parity_err,
		output crc_err, output strobe_en, output strobe_edge, output cke,
		input alert_n);
	modport dev (input cmd_valid, input cmd, input cmd_parity_err,
		input crc_err, input strobe_en, input strobe_edge, input cke,
		output alert_n);
endinterface : dmt_link_if

//--- core/dmt_device.sv
// Device end: alert generation, write start and power-down gating
`timescale 1ns/1ps
module dmt_device
	import dmt_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	dmt_link_if.dev link,
	input wire logic BC4_FIXED_IN,
	output logic WRITE_START_OUT,
	output logic MODE_APPLIED_OUT,
	output logic LOW_POWER_OUT,
	output logic CMD_EXEC_OUT
);
	logic [CNT_W-1:0] par_cnt_reg, par_cnt_next;
	logic [CNT_W-1:0] crc_cnt_reg, crc_cnt_next;
	logic [CNT_W-1:0] unk_cnt_reg, unk_cnt_next;
	logic [CNT_W-1:0] mod_cnt_reg, mod_cnt_next;
	logic [CNT_W-1:0] wr_cnt_reg, wr_cnt_next;
	logic [CNT_W-1:0] busy_cnt_reg, busy_cnt_next;
	logic alert_n_reg, alert_n_next;
	logic ws_reg, ws_next, ma_reg, ma_next, lp_reg, lp_next, ex_reg, ex_next;
	always_comb begin
		par_cnt_next = par_cnt_reg;
		crc_cnt_next = crc_cnt_reg;
		unk_cnt_next = (unk_cnt_reg != '0) ? unk_cnt_reg - 1'b1 : unk_cnt_reg;
		mod_cnt_next = (mod_cnt_reg != '0) ? mod_cnt_reg - 1'b1 : mod_cnt_reg;
		wr_cnt_next = (wr_cnt_reg != '0) ? wr_cnt_reg - 1'b1 : wr_cnt_reg;
		busy_cnt_next = (busy_cnt_reg != '0) ? busy_cnt_reg - 1'b1 : busy_cnt_reg;
		ma_next = (mod_cnt_reg == CNT_W'(1));
		ws_next = (wr_cnt_reg == CNT_W'(1));
		ex_next = 1'b0;
		// Par counter: delay phase above hold length, then hold phase
		if (par_cnt_reg != '0)
			par_cnt_next = par_cnt_reg - 1'b1;
		if (crc_cnt_reg != '0)
			crc_cnt_next = crc_cnt_reg - 1'b1;
		if (link.cmd_valid && link.cmd_parity_err) begin
			par_cnt_next = CNT_W'(PAR_ALERT_ON_CYC + PAR_ALERT_HOLD_CYC);
			unk_cnt_next = CNT_W'(PARITY_LATENCY_CYC);
		end else if (link.cmd_valid && unk_cnt_reg == '0) begin
			ex_next = 1'b1;
			if (link.cmd == CMD_MRS)
				mod_cnt_next = CNT_W'(UPDATE_DELAY_CYC);
			if (link.cmd == CMD_WR || link.cmd == CMD_WRA)
				wr_cnt_next = BC4_FIXED_IN ?
					CNT_W'(WRITE_LATENCY_CYC + WRITE_START_BC4_CYC) :
					CNT_W'(WRITE_LATENCY_CYC + WRITE_START_BL8_CYC);
			if (link.cmd == CMD_ACT || link.cmd == CMD_PRE ||
				link.cmd == CMD_REF || link.cmd == CMD_WRA)
				busy_cnt_next = CNT_W'(REF_NORMAL_CYC);
		end
		if (link.crc_err && crc_cnt_reg == '0)
			crc_cnt_next = CNT_W'(CRC_ALERT_DLY_CYC + CRC_ALERT_HOLD_CYC);
		alert_n_next = !((par_cnt_next != '0 &&
			par_cnt_next <= CNT_W'(PAR_ALERT_HOLD_CYC)) ||
			(crc_cnt_next != '0 && crc_cnt_next <= CNT_W'(CRC_ALERT_HOLD_CYC)));
		// Low power only once the busy time of an activate, precharge, refresh or write with auto precharge has run out
		lp_next = !link.cke && busy_cnt_reg == '0;
	end
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			par_cnt_reg <= '0;
			crc_cnt_reg <= '0;
			unk_cnt_reg <= '0;
			mod_cnt_reg <= '0;
			wr_cnt_reg <= '0;
			busy_cnt_reg <= '0;
			alert_n_reg <= 1'b1;
			ws_reg <= 1'b0;
			ma_reg <= 1'b0;
			lp_reg <= 1'b0;
			ex_reg <= 1'b0;
		end else begin
			par_cnt_reg <= par_cnt_next;
			crc_cnt_reg <= crc_cnt_next;
			unk_cnt_reg <= unk_cnt_next;
			mod_cnt_reg <= mod_cnt_next;
			wr_cnt_reg <= wr_cnt_next;
			busy_cnt_reg <= busy_cnt_next;
			alert_n_reg <= alert_n_next;
			ws_reg <= ws_next;
			ma_reg <= ma_next;
			lp_reg <= lp_next;
			ex_reg <= ex_next;
		end
	end
	assign link.alert_n = alert_n_reg;
	assign WRITE_START_OUT = ws_reg;
	assign MODE_APPLIED_OUT = ma_reg;
	assign LOW_POWER_OUT = lp_reg;
	assign CMD_EXEC_OUT = ex_reg;
endmodule : dmt_device

//--- tb/dmt_asserts.sv
// Checker: timing relations seen on the link between the two ends
`timescale 1ns/1ps
module dmt_asserts
	import dmt_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd,
	input wire logic cmd_parity_err,
	input wire logic crc_err,
	input wire logic strobe_en,
	input wire logic strobe_edge,
	input wire logic cke,
	input wire logic alert_n
);
	logic [7:0] mrs_gap_reg, mrs_gap_next, ref_gap_reg, ref_gap_next;
	logic [7:0] low_cnt_reg, low_cnt_next;
	logic par_flag_reg, par_flag_next;
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction : sat_inc
	// Gaps saturate so a quiet link never looks like a fresh command
	always_comb begin
		mrs_gap_next = sat_inc(mrs_gap_reg);
		ref_gap_next = sat_inc(ref_gap_reg);
		if (cmd_valid && cmd == CMD_MRS) mrs_gap_next = 8'h01;
		if (cmd_valid && cmd == CMD_REF) ref_gap_next = 8'h01;
		low_cnt_next = alert_n ? 8'h00 : sat_inc(low_cnt_reg);
		par_flag_next = (cmd_valid && cmd_parity_err) ||
			(par_flag_reg && !(alert_n && low_cnt_reg != 8'h00));
	end
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			mrs_gap_reg <= 8'hff;
			ref_gap_reg <= 8'hff;
			low_cnt_reg <= 8'h00;
			par_flag_reg <= 1'b0;
		end else begin
			mrs_gap_reg <= mrs_gap_next;
			ref_gap_reg <= ref_gap_next;
			low_cnt_reg <= low_cnt_next;
			par_flag_reg <= par_flag_next;
		end
	end
	default clocking dflt @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	par_alert_on_a: assert property (
		cmd_valid && cmd_parity_err |-> ##[1:7] !alert_n)
		else $error("parity alert late");
	par_alert_width_a: assert property (
		$rose(alert_n) && par_flag_reg |-> low_cnt_reg >= PAR_ALERT_MIN_CYC
		&& low_cnt_reg <= PAR_ALERT_MAX_CYC)
		else $error("parity alert width wrong");
	alert_max_a: assert property (
		!alert_n |-> low_cnt_reg < PAR_ALERT_MAX_CYC)
		else $error("alert held too long");
	crc_alert_on_a: assert property (
		crc_err |-> ##[1:2] !alert_n)
		else $error("crc alert late");
	crc_alert_width_a: assert property (
		$rose(alert_n) && !par_flag_reg |-> low_cnt_reg >=
		CRC_ALERT_WIDTH_MIN_CYC && low_cnt_reg <= CRC_ALERT_WIDTH_MAX_CYC)
		else $error("crc alert width wrong");
	mode_gap_a: assert property (
		cmd_valid && cmd == CMD_MRS |-> mrs_gap_reg >= UPDATE_DELAY_CYC)
		else $error("mode writes too close");
	level_edge_a: assert property (
		strobe_edge |-> mrs_gap_reg >= LEVEL_FIRST_STROBE_CYC)
		else $error("strobe edge too early");
	level_enable_a: assert property (
		$rose(strobe_en) |-> mrs_gap_reg >= LEVEL_STROBE_EN_CYC)
		else $error("strobe enable too early");
	refresh_gap_a: assert property (
		cmd_valid && (cmd == CMD_ACT || cmd == CMD_REF) |->
		ref_gap_reg >= REF_QUAD_CYC)
		else $error("command inside refresh period");
endmodule : dmt_asserts

//--- tb/ddr4_mode_alert_refresh_timing_tb.sv
// Testbench: controller and device joined, driven over APB
`timescale 1ns/1ps
module ddr4_mode_alert_refresh_timing_tb;
	import dmt_pkg::*;
	logic clk, rstn, psel, pen, pwr, bc4, sl, pready, pslverr;
	logic wstart, mapplied, lowp, cexec, pa;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, w;
	int errors, checked, cyc, t_mode, t_ws, t_af, t_ar, t_se, t_sen, t_crc, d;
	int t_ex, c0;
	int t_cmd [16];
	dmt_link_if link();
	dmt_controller i_dmt_controller(.CORE_CLK_IN(clk), .RSTN_IN(rstn),
		.link(link), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
	dmt_device i_dmt_device(.CORE_CLK_IN(clk), .RSTN_IN(rstn), .link(link),
		.BC4_FIXED_IN(bc4), .WRITE_START_OUT(wstart),
		.MODE_APPLIED_OUT(mapplied), .LOW_POWER_OUT(lowp),
		.CMD_EXEC_OUT(cexec));
	dmt_asserts i_dmt_asserts(.CORE_CLK_IN(clk), .RSTN_IN(rstn),
		.cmd_valid(link.cmd_valid), .cmd(link.cmd),
		.cmd_parity_err(link.cmd_parity_err), .crc_err(link.crc_err),
		.strobe_en(link.strobe_en), .strobe_edge(link.strobe_edge),
		.cke(link.cke), .alert_n(link.alert_n));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic int ref_exp(input int m);
		int ns;
		ns = (m == 2) ? 160 : (m == 1) ? 260 : 350;
		return (ns * 1000 + 9999) / 10000;
	endfunction : ref_exp
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	// Ends one idle edge late so the next setup never collides
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] dat);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic idle();
		do apb(1'b0, 12'h008, 32'h0); while (rd[7] !== 1'b1);
	endtask : idle
	task automatic cmd(input logic [31:0] c);
		apb(1'b1, 12'h000, c);
		idle();
	endtask : cmd
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (link.cmd_valid) t_cmd[link.cmd] = cyc;
		if (cexec) t_ex = cyc;
		if (link.crc_err) t_crc = cyc;
		if (mapplied) t_mode = cyc;
		if (wstart) t_ws = cyc;
		if (pa && !link.alert_n) t_af = cyc;
		if (!pa && link.alert_n) t_ar = cyc;
		if (link.strobe_edge && t_se < 0) t_se = cyc;
		if (link.strobe_en && t_sen < 0) t_sen = cyc;
		pa = link.alert_n;
		if (cyc > 20000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bc4 = 1'b0;
		pa = 1'b1;
		seed = 32'd41;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check("alert idle", 32'(link.alert_n), 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		check("status idle", 32'(rd[7]), 32'h1);
		apb(1'b0, 12'h0f0, 32'h0);
		check("unmapped slverr", 32'(sl), 32'h1);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, 12'h004, 32'h20 | 32'(m));
			cmd(32'(CMD_REF));
			cmd(32'(CMD_ACT));
			d = t_cmd[CMD_ACT] - t_cmd[CMD_REF];
			check("ref to act", 32'(d >= ref_exp(m)), 32'h1);
		end
		cmd(32'(CMD_MRS));
		repeat (30) @(posedge clk);
		check("mode applied", 32'(t_mode - t_cmd[CMD_MRS]), 32'd25);
		t_ar = -1;
		apb(1'b1, 12'h000, 32'h11);
		apb(1'b1, 12'h000, 32'(CMD_ACT));
		idle();
		while (t_ar < 0) @(posedge clk);
		d = t_af - t_cmd[CMD_MRS];
		check("parity delay", 32'(d inside {[1:7]}), 32'h1);
		check("parity width", 32'(t_ar - t_af inside {[88:176]}), 32'h1);
		d = t_cmd[CMD_ACT] - t_cmd[CMD_MRS];
		check("act in window", 32'(d <= 6), 32'h1);
		check("act not run", 32'(t_ex < t_cmd[CMD_ACT]), 32'h1);
		t_ar = -1;
		cmd(32'h25);
		while (t_ar < 0) @(posedge clk);
		check("crc delay", 32'(t_af - t_crc inside {[1:2]}), 32'h1);
		check("crc width", 32'(t_ar - t_af inside {[6:10]}), 32'h1);
		// Let the crc write start pass so it is not taken for the next one
		repeat (16) @(posedge clk);
		// Random burst mode per write; fixed chop starts earlier
		for (int i = 0; i < 6; i++) begin
			w = xs();
			bc4 <= w[0];
			t_ws = -1;
			cmd(32'(CMD_WR));
			while (t_ws < 0) @(posedge clk);
			d = WRITE_LATENCY_CYC + 1 + (bc4 ? 2 : 4);
			check("write start", 32'(t_ws - t_cmd[CMD_WR]), 32'(d));
			check("write exec", 32'(t_ex - t_cmd[CMD_WR]), 32'h1);
		end
		apb(1'b1, 12'h004, 32'h22);
		apb(1'b1, 12'h000, 32'(CMD_REF));
		apb(1'b1, 12'h004, 32'h2);
		repeat (10) @(posedge clk);
		check("low power early", 32'(lowp), 32'h0);
		idle();
		repeat (40) @(posedge clk);
		check("low power late", 32'(lowp), 32'h1);
		// Persistent parity: only deselects until status is cleared
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h004, 32'h28);
		t_ar = -1;
		cmd(32'h11);
		while (link.alert_n) @(posedge clk);
		repeat (4) @(posedge clk);
		d = t_cmd[CMD_ACT];
		apb(1'b1, 12'h000, 32'(CMD_ACT));
		apb(1'b0, 12'h008, 32'h0);
		check("persist blocked", 32'(rd[0]), 32'h1);
		check("persist deselect", 32'(t_cmd[CMD_ACT] == d), 32'h1);
		while (t_ar < 0) @(posedge clk);
		apb(1'b1, 12'h008, 32'h0);
		idle();
		check("persist release", 32'(t_cmd[CMD_ACT] > d), 32'h1);
		apb(1'b1, 12'h004, 32'h20);
		t_se = -1;
		t_sen = -1;
		cmd(32'h41);
		while (t_se < 0) @(posedge clk);
		check("strobe en gap", 32'(t_sen - t_cmd[CMD_MRS] >= 25), 32'h1);
		check("strobe edge gap", 32'(t_se - t_cmd[CMD_MRS] >= 40), 32'h1);
		// Unlocked loop holds a read, not precharge
		apb(1'b1, 12'h004, 32'h30);
		c0 = cyc;
		cmd(32'(CMD_PRE));
		check("pre not held", 32'(t_cmd[CMD_PRE] - c0 < 20), 32'h1);
		apb(1'b1, 12'h000, 32'(CMD_RD));
		apb(1'b0, 12'h008, 32'h0);
		check("read held", 32'(rd[0]), 32'h1);
		idle();
		apb(1'b1, 12'h004, 32'h24);
		cmd(32'(CMD_WR));
		apb(1'b0, 12'h008, 32'h0);
		check("write busy", 32'(rd[6]), 32'h1);
		repeat (20) @(posedge clk);
		apb(1'b0, 12'h008, 32'h0);
		check("write done", 32'(rd[6]), 32'h0);
		end_sim();
	end
endmodule : ddr4_mode_alert_refresh_timing_tb
